/* File: verif/test_universal_serial_two_wire_slave.sv */
// self-checking bench: slave unit and bus master joined over the two-wire link
`timescale 1ns/1ps
`include "ustw_defines.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_universal_serial_two_wire_slave;
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr, timer_ovf, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic start_irq, ovf_irq, cmd_valid, cmd_ack_bit, cmd_ready, done, rx_ack;
   logic [2:0] cmd;
   logic [7:0] cmd_data, rx_data;
   int bad_count = 0;
   int compares = 0;
   ustw_bus_if bus ();
   ustw_slave u_ustw_slave (.core_clk(core_clk), .rst(rst), .bus(bus), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_ovf(timer_ovf), .start_irq(start_irq),
      .ovf_irq(ovf_irq));
   ustw_master u_ustw_master (.core_clk(core_clk), .rst(rst), .bus(bus),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_data(cmd_data), .cmd_ack_bit(cmd_ack_bit),
      .cmd_ready(cmd_ready), .done(done), .rx_data(rx_data), .rx_ack(rx_ack));
   ustw_props u_ustw_props (.core_clk(core_clk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
      .slv_scl_oe(bus.slv_scl_oe), .slv_sda_oe(bus.slv_sda_oe),
      .mst_scl_oe(bus.mst_scl_oe), .mst_sda_oe(bus.mst_sda_oe));
   // 100 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic summarize;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // bounded wait for an interrupt line to reach a level
   task automatic wait_irq(input logic sel, input logic lvl);
      int n;
      n = 0;
      while (((sel ? ovf_irq : start_irq) !== lvl) && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 3000) bad_count++;
   endtask
   // issue one master command and wait for its completion pulse
   task automatic mst(input logic [2:0] c, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd <= c;
      cmd_data <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 50);
      cmd_valid <= 1'b0;
      while (done !== 1'b1 && n < 5000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 5000) bad_count++;
   endtask
   // slave software for one byte plus its acknowledge bit
   task automatic slv_byte(input logic [7:0] tx, input logic ack, input logic [7:0] ex);
      apb(1'b1, `USTW_A_DATA, {24'h000000, tx});
      apb(1'b1, `USTW_A_STAT, 32'h000000C0);
      wait_irq(1'b1, 1'b0);
      wait_irq(1'b1, 1'b1);
      apb(1'b0, `USTW_A_STAT, 32'h00000000);
      `CHK("status after byte", 8'h40, rd[7:0])
      apb(1'b0, `USTW_A_DATA, 32'h00000000);
      `CHK("shifted byte", ex, rd[7:0])
      apb(1'b1, `USTW_A_DATA, ack ? 32'h00000000 : 32'h000000FF);
      apb(1'b1, `USTW_A_STAT, 32'h0000004E);
      wait_irq(1'b1, 1'b0);
      wait_irq(1'b1, 1'b1);
   endtask
   // watchdog sized well above the expected few thousand cycles
   initial begin
      #300000;
      bad_count++;
      summarize();
   end
   // main sequence
   initial begin
      {rst, psel, penable, pwrite, timer_ovf, cmd_valid} = 6'h20;
      {paddr, pwdata, cmd, cmd_data, cmd_ack_bit} = '0;
      cmd_ack_bit = 1'b1;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      apb(1'b0, `USTW_A_STAT, 32'h00000000);
      `CHK("status reset", 32'h00000000, rd)
      apb(1'b0, 12'h020, 32'h00000000);
      `CHK("unmapped error", 1'b1, err)
      apb(1'b1, `USTW_A_DATA, 32'h000000FF);
      apb(1'b1, `USTW_A_CTRL, 32'h000003E8);
      fork
         begin
            mst(ustw_pkg::USTW_CMD_START, 8'hFF);
            mst(ustw_pkg::USTW_CMD_BYTE, 8'hA4);
            `CHK("address ack", 1'b0, rx_ack)
            mst(ustw_pkg::USTW_CMD_BYTE, 8'h5A);
            `CHK("data ack", 1'b0, rx_ack)
            mst(ustw_pkg::USTW_CMD_BYTE, 8'hC3);
            `CHK("withheld ack", 1'b1, rx_ack)
            mst(ustw_pkg::USTW_CMD_START, 8'hFF);
            mst(ustw_pkg::USTW_CMD_BYTE, 8'hA5);
            `CHK("read address ack", 1'b0, rx_ack)
            mst(ustw_pkg::USTW_CMD_BYTE, 8'hFF);
            `CHK("read data", 8'h96, rx_data)
            mst(ustw_pkg::USTW_CMD_STOP, 8'hFF);
         end
         begin
            wait_irq(1'b0, 1'b1);
            // clear only once the start hold has caught the falling edge
            @(posedge core_clk iff bus.slv_scl_oe === 1'b1);
            apb(1'b0, `USTW_A_STAT, 32'h00000000);
            `CHK("start flag", 1'b1, rd[7])
            slv_byte(8'hFF, 1'b1, 8'hA4);
            slv_byte(8'hFF, 1'b1, 8'h5A);
            slv_byte(8'hFF, 1'b0, 8'hC3);
            apb(1'b1, `USTW_A_STAT, 32'h00000040);
            wait_irq(1'b0, 1'b1);
            @(posedge core_clk iff bus.slv_scl_oe === 1'b1);
            apb(1'b0, `USTW_A_STAT, 32'h00000000);
            `CHK("repeated start flag", 1'b1, rd[7])
            slv_byte(8'hFF, 1'b1, 8'hA5);
            slv_byte(8'h96, 1'b0, 8'h96);
            apb(1'b1, `USTW_A_STAT, 32'h00000040);
         end
      join
      apb(1'b1, `USTW_A_CTRL, 32'h00000040);
      apb(1'b1, `USTW_A_STAT, 32'h000000EF);
      apb(1'b1, `USTW_A_CMD, 32'h00000002);
      wait_irq(1'b1, 1'b1);
      apb(1'b0, `USTW_A_STAT, 32'h00000000);
      `CHK("strobe overflow", 8'h40, rd[7:0])
      apb(1'b1, `USTW_A_CTRL, 32'h00000044);
      apb(1'b1, `USTW_A_STAT, 32'h000000EE);
      repeat (2) begin
         @(posedge core_clk);
         timer_ovf <= 1'b1;
         @(posedge core_clk);
         timer_ovf <= 1'b0;
      end
      wait_irq(1'b1, 1'b1);
      apb(1'b0, `USTW_A_STAT, 32'h00000000);
      `CHK("timer chain overflow", 8'h40, rd[7:0])
      apb(1'b1, `USTW_A_CTRL, 32'h00000058);
      apb(1'b1, `USTW_A_STAT, 32'h000000EF);
      // first raw clock only falls (F wraps to 0), second rises and falls
      mst(ustw_pkg::USTW_CMD_RAW, 8'hFF);
      mst(ustw_pkg::USTW_CMD_RAW, 8'hFF);
      repeat (8) @(posedge core_clk);
      apb(1'b0, `USTW_A_STAT, 32'h00000000);
      `CHK("edge count and flags", 8'hC2, rd[7:0])
      summarize();
   end
endmodule

/* File: verif/ustw_props.sv */
// wire-level checks on the two-wire link between slave unit and bus master
`timescale 1ns/1ps
module ustw_props (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic slv_scl_oe,
   input wire logic slv_sda_oe,
   input wire logic mst_scl_oe,
   input wire logic mst_sda_oe
);
   logic [7:0] scl_hi_r;
   default clocking dcb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // run length of scl high; a stretched clock shows as a short run
   always_ff @(posedge core_clk) begin
      if (rst || !scl) begin
         scl_hi_r <= 8'h00;
      end else if (scl_hi_r != 8'hFF) begin
         scl_hi_r <= scl_hi_r + 8'h01;
      end
   end
   property p_quiet_rst;
      $fell(rst) |-> !(slv_scl_oe || slv_sda_oe || mst_scl_oe || mst_sda_oe);
   endproperty
   a_quiet_rst: assert property (p_quiet_rst)
      else $error("line driven right after reset");
   property p_hold_after_fall;
      $rose(slv_scl_oe) |-> mst_scl_oe;
   endproperty
   a_hold_after_fall: assert property (p_hold_after_fall)
      else $error("slave pulled clock while master released it");
   property p_start_hold;
      scl && $fell(sda) |-> ##[1:60] $rose(mst_scl_oe) ##[1:30] slv_scl_oe;
   endproperty
   a_start_hold: assert property (p_start_hold)
      else $error("no clock hold after start");
   property p_mst_waits_high;
      $rose(mst_scl_oe) |-> scl_hi_r >= 8'h08;
   endproperty
   a_mst_waits_high: assert property (p_mst_waits_high)
      else $error("master pulled clock before it was seen high");
   property p_mst_low_half;
      $rose(mst_scl_oe) |=> mst_scl_oe [*8];
   endproperty
   a_mst_low_half: assert property (p_mst_low_half)
      else $error("master low half too short");
   property p_scl_high_min;
      $rose(scl) |-> scl [*8];
   endproperty
   a_scl_high_min: assert property (p_scl_high_min)
      else $error("clock high half too short");
   property p_slv_sda_scl_low;
      $changed(slv_sda_oe) |-> !scl;
   endproperty
   a_slv_sda_scl_low: assert property (p_slv_sda_scl_low)
      else $error("slave data changed while clock high");
   property p_ack_steady;
      $rose(scl) && slv_sda_oe |-> slv_sda_oe [*8];
   endproperty
   a_ack_steady: assert property (p_ack_steady)
      else $error("slave low data not held through clock high");
   c_start: cover property (scl && $fell(sda));
   c_stop: cover property (scl && $rose(sda));
   c_ack: cover property ($rose(scl) && slv_sda_oe);
   c_stretch: cover property (slv_scl_oe && !mst_scl_oe);
endmodule

/* File: verilog/ustw_bus_if.sv */
// open-drain clock and data wires joining slave shift unit and bus master
`timescale 1ns/1ps
interface ustw_bus_if;
   logic scl;
   logic sda;
   logic slv_scl_oe;
   logic slv_sda_oe;
   logic mst_scl_oe;
   logic mst_sda_oe;
   // wired-and: any enabled driver pulls low
   assign scl = ~(slv_scl_oe | mst_scl_oe);
   assign sda = ~(slv_sda_oe | mst_sda_oe);
   modport slave (input scl, input sda, output slv_scl_oe, output slv_sda_oe);
   modport master (input scl, input sda, output mst_scl_oe, output mst_sda_oe);
endinterface

/* File: verilog/ustw_defines.svh */
// shared constants for the two-wire shift unit and its bus master
`ifndef USTW_DEFINES_SVH
`define USTW_DEFINES_SVH
`define USTW_CNT_ACK_PRESET 4'hE
`define USTW_CNT_MAX 4'hF
`define USTW_CNT_ZERO 4'h0
`define USTW_MSB 7
`define USTW_DLY_NS 100
`define USTW_CLK_NS 10
`define USTW_DLY_CYC ((`USTW_DLY_NS + `USTW_CLK_NS - 1) / `USTW_CLK_NS)
`define USTW_HALF_CYC 8'h14
`define USTW_CS_SOFT 2'h0
`define USTW_CS_TIMER 2'h1
`define USTW_CS_EXT_POS 2'h2
`define USTW_CS_EXT_NEG 2'h3
`define USTW_WM_OFF 2'h0
`define USTW_WM_THREE 2'h1
`define USTW_WM_TWO 2'h2
`define USTW_A_CTRL 12'h000
`define USTW_A_STAT 12'h004
`define USTW_A_DATA 12'h008
`define USTW_A_CMD 12'h00C
`define USTW_A_RX 12'h010
`endif

/* File: verilog/ustw_master.sv */
// two-wire bus master: makes clock, start, stop and byte transfers
`timescale 1ns/1ps
module ustw_master (
   input wire logic core_clk,
   input wire logic rst,
   ustw_bus_if.master bus,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_ack_bit,
   output logic cmd_ready,
   output logic done,
   output logic [7:0] rx_data,
   output logic rx_ack
);
   `include "ustw_defines.svh"
   ustw_pkg::ustw_mst_state_t state_r;
   logic [7:0] tim_r;
   logic [3:0] bit_r;
   logic [8:0] tx_r;
   logic [8:0] rx_r;
   logic [2:0] op_r;
   logic scl_m_r, scl_s_r, sda_m_r, sda_s_r;
   // pins come from outside this clock's domain
   always_ff @(posedge core_clk) begin
      if (rst) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
      end else begin
         scl_m_r <= bus.scl;
         scl_s_r <= scl_m_r;
         sda_m_r <= bus.sda;
         sda_s_r <= sda_m_r;
      end
   end
   // op: start -> data low while clock high byte: 9 clocks; stop
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= ustw_pkg::USTW_M_IDLE;
         tim_r <= 8'h00;
         bit_r <= 4'h0;
         tx_r <= 9'h1FF;
         rx_r <= 9'h000;
         op_r <= 3'h0;
         bus.mst_scl_oe <= 1'b0;
         bus.mst_sda_oe <= 1'b0;
         cmd_ready <= 1'b0;
         done <= 1'b0;
         rx_data <= 8'h00;
         rx_ack <= 1'b1;
      end else begin
         done <= 1'b0;
         cmd_ready <= 1'b0;
         case (state_r)
            ustw_pkg::USTW_M_IDLE: begin
               if (cmd_valid && !cmd_ready) begin
                  cmd_ready <= 1'b1;
                  op_r <= cmd;
                  tim_r <= `USTW_HALF_CYC;
                  bit_r <= 4'h0;
                  tx_r <= {cmd_data, cmd_ack_bit};
                  if (cmd == ustw_pkg::USTW_CMD_START) begin
                     bus.mst_scl_oe <= 1'b0;
                     bus.mst_sda_oe <= 1'b0;
                     state_r <= ustw_pkg::USTW_M_WAIT;
                  end else if (cmd == ustw_pkg::USTW_CMD_STOP) begin
                     bus.mst_sda_oe <= 1'b1;
                     state_r <= ustw_pkg::USTW_M_LOW;
                  end else begin
                     bus.mst_sda_oe <= ~cmd_data[`USTW_MSB];
                     state_r <= ustw_pkg::USTW_M_LOW;
                  end
               end
            end
            ustw_pkg::USTW_M_LOW: begin
               // clock low half: release at end of it
               if (tim_r == 8'h00) begin
                  bus.mst_scl_oe <= 1'b0;
                  tim_r <= `USTW_HALF_CYC;
                  state_r <= ustw_pkg::USTW_M_WAIT;
               end else begin
                  tim_r <= tim_r - 8'h01;
               end
            end
            ustw_pkg::USTW_M_WAIT: begin
               // slave may stretch: wait until clock really high
               if (scl_s_r && tim_r == 8'h00) begin
                  if (op_r == ustw_pkg::USTW_CMD_START) begin
                     bus.mst_sda_oe <= 1'b1;
                     tim_r <= `USTW_HALF_CYC;
                     state_r <= ustw_pkg::USTW_M_HIGH;
                  end else if (op_r == ustw_pkg::USTW_CMD_STOP) begin
                     bus.mst_sda_oe <= 1'b0;
                     state_r <= ustw_pkg::USTW_M_DONE;
                  end else begin
                     rx_r <= {rx_r[7:0], sda_s_r};
                     tim_r <= `USTW_HALF_CYC;
                     state_r <= ustw_pkg::USTW_M_HIGH;
                  end
               end else if (scl_s_r) begin
                  tim_r <= tim_r - 8'h01;
               end
            end
            ustw_pkg::USTW_M_HIGH: begin
               // master alone drives clock low
               if (tim_r == 8'h00) begin
                  bus.mst_scl_oe <= 1'b1;
                  tim_r <= `USTW_HALF_CYC;
                  if (op_r == ustw_pkg::USTW_CMD_START
                        || op_r == ustw_pkg::USTW_CMD_RAW || bit_r == 4'h8) begin
                     state_r <= ustw_pkg::USTW_M_DONE;
                  end else begin
                     // next bit driven in the same cycle as the falling edge
                     bus.mst_sda_oe <= ~tx_r[7];
                     tx_r <= {tx_r[7:0], 1'b1};
                     bit_r <= bit_r + 4'h1;
                     state_r <= ustw_pkg::USTW_M_LOW;
                  end
               end else begin
                  tim_r <= tim_r - 8'h01;
               end
            end
            ustw_pkg::USTW_M_DONE: begin
               done <= 1'b1;
               rx_data <= rx_r[8:1];
               rx_ack <= rx_r[0];
               state_r <= ustw_pkg::USTW_M_IDLE;
            end
            default: begin
               state_r <= ustw_pkg::USTW_M_IDLE;
            end
         endcase
      end
   end
endmodule

/* File: verilog/ustw_pkg.sv */
// types for the bus master of the two-wire link: its states and command codes
package ustw_pkg;
   typedef enum logic [4:0] {
      USTW_M_IDLE = 5'h01,
      USTW_M_LOW = 5'h02,
      USTW_M_HIGH = 5'h04,
      USTW_M_WAIT = 5'h08,
      USTW_M_DONE = 5'h10
   } ustw_mst_state_t;
   typedef enum logic [2:0] {
      USTW_CMD_START = 3'h0,
      USTW_CMD_BYTE = 3'h1,
      USTW_CMD_STOP = 3'h2,
      USTW_CMD_RAW = 3'h3
   } ustw_cmd_t;
endpackage

/* File: verilog/ustw_slave.sv */
// slave-side universal serial shift unit: shift register, edge counter, start detector
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module ustw_slave (
   input wire logic core_clk,
   input wire logic rst,
   ustw_bus_if.slave bus,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_ovf,
   output logic start_irq,
   output logic ovf_irq
);
   `include "ustw_defines.svh"
   // control fields
   logic [1:0] wire_mode_r;
   logic clock_source_select_high_r;
   logic clock_source_select_low_r;
   logic clock_strobe_select_r;
   logic start_ie_r;
   logic ovf_ie_r;
   logic data_pin_output_bit_r;
   logic data_pin_direction_bit_r;
   logic clk_pin_out_r;
   logic clk_pin_dir_r;
   logic [7:0] shift_data_reg_r;
   logic [3:0] cnt_r;
   logic start_cond_flag_r;
   logic counter_overflow_flag_r;
   logic stop_flag_r;
   logic start_hold_r;
   logic sda_in_r;
   // synchronisers, plain two flops: no filtering in this mode
   logic scl_m_r, scl_s_r, scl_d_r;
   logic sda_m_r, sda_s_r;
   logic [`USTW_DLY_CYC:0] sda_dly_r;
   logic tim_d_r;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
         sda_dly_r <= '1;
         tim_d_r <= 1'b0;
      end else begin
         scl_m_r <= bus.scl;
         scl_s_r <= scl_m_r;
         scl_d_r <= scl_s_r;
         sda_m_r <= bus.sda;
         sda_s_r <= sda_m_r;
         // data delayed behind clock so clock level is stable at decision
         sda_dly_r <= {sda_dly_r[`USTW_DLY_CYC-1:0], sda_s_r};
         tim_d_r <= timer_ovf;
      end
   end
   logic scl_rise, scl_fall, sda_fall_dly, sda_rise_dly, tim_edge, two_wire, ext_clk;
   assign scl_rise = scl_s_r & ~scl_d_r;
   assign scl_fall = ~scl_s_r & scl_d_r;
   assign sda_fall_dly = ~sda_dly_r[`USTW_DLY_CYC-1] & sda_dly_r[`USTW_DLY_CYC];
   assign sda_rise_dly = sda_dly_r[`USTW_DLY_CYC-1] & ~sda_dly_r[`USTW_DLY_CYC];
   assign tim_edge = timer_ovf & ~tim_d_r;
   assign two_wire = (wire_mode_r == `USTW_WM_TWO);
   assign ext_clk = clock_source_select_high_r;
   // apb decode; zero-wait slave
   logic wr_en, rd_en, strobe_wr, toggle_wr;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   assign strobe_wr = wr_en && paddr == `USTW_A_CMD && pwdata[1];
   assign toggle_wr = wr_en && paddr == `USTW_A_CMD && pwdata[0];
   logic stat_wr;
   assign stat_wr = wr_en && paddr == `USTW_A_STAT;
   // shift clock and counter clock selection
   logic sh_tick, cnt_tick, sample_tick;
   always_comb begin
      sh_tick = 1'b0;
      cnt_tick = 1'b0;
      sample_tick = 1'b0;
      if (!ext_clk && !clock_source_select_low_r) begin
         sh_tick = strobe_wr;
         cnt_tick = strobe_wr;
         sample_tick = strobe_wr;
      end else if (!ext_clk) begin
         sh_tick = tim_edge;
         cnt_tick = tim_edge;
         sample_tick = tim_edge;
      end else begin
         // positive select samples on rise negative is mirror
         sample_tick = clock_source_select_low_r ? scl_fall : scl_rise;
         sh_tick = sample_tick;
         // both edges count when externally clocked with strobe select clear; with it set the toggle command counts
         cnt_tick = clock_strobe_select_r ? toggle_wr : (scl_rise | scl_fall);
      end
   end
   // input bit is latched; output bit moves on falling edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sda_in_r <= 1'b1;
      end else if (sample_tick) begin
         sda_in_r <= sda_s_r;
      end
   end
   // shift register, msb first shifted on falling clock edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         shift_data_reg_r <= 8'h00;
      end else if (wr_en && paddr == `USTW_A_DATA) begin
         shift_data_reg_r <= pwdata[7:0];
      end else if (ext_clk && !clock_source_select_low_r && scl_fall) begin
         shift_data_reg_r <= {shift_data_reg_r[6:0], sda_in_r};
      end else if (!(ext_clk && !clock_source_select_low_r) && sh_tick) begin
         shift_data_reg_r <= {shift_data_reg_r[6:0], ext_clk ? sda_in_r : sda_s_r};
      end
   end
   // counter; overflow flag marks end of transfer
   logic cnt_wrap;
   assign cnt_wrap = cnt_tick && cnt_r == `USTW_CNT_MAX;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_r <= `USTW_CNT_ZERO;
      end else if (stat_wr) begin
         cnt_r <= pwdata[3:0];
      end else if (cnt_tick) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
   // overflow flag; set wins over write-one clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         counter_overflow_flag_r <= 1'b0;
      end else if (cnt_wrap) begin
         counter_overflow_flag_r <= 1'b1;
      end else if (stat_wr && pwdata[6]) begin
         counter_overflow_flag_r <= 1'b0;
      end
   end
   // start detection: two-wire start, or in other modes any clock edge when externally clocked with strobe select clear
   logic start_evt, stop_evt;
   assign start_evt = two_wire ? (sda_fall_dly & scl_s_r)
      : (ext_clk && !clock_strobe_select_r && wire_mode_r != `USTW_WM_TWO
         && (scl_rise | scl_fall));
   assign stop_evt = two_wire & sda_rise_dly & scl_s_r;
   // sampled on core clock; a sleeping design keeps core_clk gated, so the
   // wake path lies outside this block
   always_ff @(posedge core_clk) begin
      if (rst) begin
         start_cond_flag_r <= 1'b0;
      end else if (start_evt) begin
         start_cond_flag_r <= 1'b1;
      end else if (stat_wr && pwdata[7]) begin
         start_cond_flag_r <= 1'b0;
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stop_flag_r <= 1'b0;
      end else if (stop_evt) begin
         stop_flag_r <= 1'b1;
      end else if (stat_wr && pwdata[5]) begin
         stop_flag_r <= 1'b0;
      end
   end
   // hold clock after start's first falling edge until flag cleared
   always_ff @(posedge core_clk) begin
      if (rst) begin
         start_hold_r <= 1'b0;
      end else if (!start_cond_flag_r || !two_wire) begin
         start_hold_r <= 1'b0;
      end else if (scl_fall) begin
         start_hold_r <= 1'b1;
      end
   end
   // pin drivers: clock held by start or overflow
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bus.slv_scl_oe <= 1'b0;
         bus.slv_sda_oe <= 1'b0;
      end else begin
         bus.slv_scl_oe <= (two_wire & (start_hold_r | start_cond_flag_r & scl_fall
            | counter_overflow_flag_r | cnt_wrap))
            | (clk_pin_dir_r & ~clk_pin_out_r);
         // drive low only: data bit and port bit both gate
         bus.slv_sda_oe <= data_pin_direction_bit_r
            & ~(shift_data_reg_r[`USTW_MSB] & data_pin_output_bit_r);
      end
   end
   // control register write
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wire_mode_r <= `USTW_WM_OFF;
         clock_source_select_high_r <= 1'b0;
         clock_source_select_low_r <= 1'b0;
         clock_strobe_select_r <= 1'b0;
         start_ie_r <= 1'b0;
         ovf_ie_r <= 1'b0;
         data_pin_output_bit_r <= 1'b1;
         data_pin_direction_bit_r <= 1'b0;
         clk_pin_dir_r <= 1'b0;
      end else if (wr_en && paddr == `USTW_A_CTRL) begin
         start_ie_r <= pwdata[7];
         ovf_ie_r <= pwdata[6];
         wire_mode_r <= pwdata[5:4];
         clock_source_select_high_r <= pwdata[3];
         clock_source_select_low_r <= pwdata[2];
         clock_strobe_select_r <= pwdata[1];
         data_pin_output_bit_r <= pwdata[8];
         data_pin_direction_bit_r <= pwdata[9];
         clk_pin_dir_r <= pwdata[10];
      end
   end
   // clock pin output bit, toggled by command
   always_ff @(posedge core_clk) begin
      if (rst) begin
         clk_pin_out_r <= 1'b1;
      end else if (toggle_wr) begin
         clk_pin_out_r <= ~clk_pin_out_r;
      end
   end
   // read mux and registered outputs
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         start_irq <= 1'b0;
         ovf_irq <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr > `USTW_A_CMD);
         start_irq <= start_cond_flag_r & start_ie_r;
         ovf_irq <= counter_overflow_flag_r & ovf_ie_r;
         if (rd_en) begin
            if (paddr == `USTW_A_CTRL) begin
               prdata <= {21'h0, clk_pin_dir_r, data_pin_direction_bit_r,
                  data_pin_output_bit_r, start_ie_r, ovf_ie_r, wire_mode_r,
                  clock_source_select_high_r, clock_source_select_low_r,
                  clock_strobe_select_r, 1'b0};
            end else if (paddr == `USTW_A_STAT) begin
               prdata <= {24'h0, start_cond_flag_r, counter_overflow_flag_r,
                  stop_flag_r, 1'b0, cnt_r};
            end else if (paddr == `USTW_A_DATA) begin
               prdata <= {24'h0, shift_data_reg_r};
            end else begin
               prdata <= 32'h0000_0000;
            end
         end
      end
   end
endmodule
